// ### hw/channel_fault_protection.sv
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
module channel_fault_protection
  import fault_prot_pkg::*;
(
  input wire logic ref_clk_i, // 250 MHz system clock
  input wire logic sys_rst_i, // synchronous reset, high
  input wire logic clk_en_i, // clock enable
  input wire logic [fault_prot_pkg::NUM_CH-1:0] oc_cmp_i, // overcurrent comparators, async
  input wire logic [fault_prot_pkg::NUM_CH-1:0] ot_hot_i, // hot, drops after hysteresis
  input wire logic bat_ov_i, // battery overvoltage detector, async
  input wire logic cp_uv_i, // charge pump undervoltage, async
  input wire logic [fault_prot_pkg::ADDR_W-1:0] addr_i, // register address
  input wire logic [fault_prot_pkg::DATA_W-1:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [fault_prot_pkg::DATA_W-1:0] rdata_o, // read data, cycle after strobe
  output logic [fault_prot_pkg::NUM_CH-1:0] ch_on_o, // channel enabled
  output logic [fault_prot_pkg::SP_W-1:0] sp0_o, // channel 0 setpoint
  output logic [fault_prot_pkg::SP_W-1:0] sp1_o, // channel 1 setpoint
  output logic fault_output_low_active_o, // open drain fault pin level
  output logic fault_oe_o // pin drive enable
);
  import fault_prot_pkg::*;

  // two-stage synchronisers for pin inputs
  logic [NUM_CH-1:0] oc_s1_r, oc_s2_r, ot_s1_r, ot_s2_r;
  logic ov_s1_r, ov_s2_r, uv_s1_r, uv_s2_r;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      oc_s1_r <= '0;
      oc_s2_r <= '0;
      ot_s1_r <= '0;
      ot_s2_r <= '0;
      ov_s1_r <= 1'b0;
      ov_s2_r <= 1'b0;
      uv_s1_r <= 1'b0;
      uv_s2_r <= 1'b0;
    end else if (clk_en_i) begin
      oc_s1_r <= oc_cmp_i;
      oc_s2_r <= oc_s1_r;
      ot_s1_r <= ot_hot_i;
      ot_s2_r <= ot_s1_r;
      ov_s1_r <= bat_ov_i;
      ov_s2_r <= ov_s1_r;
      uv_s1_r <= cp_uv_i;
      uv_s2_r <= uv_s1_r;
    end
  end

  // state registers
  logic [NUM_CH-1:0] on_r, on_nxt;
  logic [SP_W-1:0] sp_r [NUM_CH], sp_nxt [NUM_CH];
  logic [NUM_CH-1:0] oc_flag_r, oc_flag_nxt, ot_flag_r, ot_flag_nxt;
  logic [NUM_CH-1:0] ot_lock_r, ot_lock_nxt;
  logic ov_flag_r, ov_flag_nxt, uv_flag_r, uv_flag_nxt, uv_lock_r, uv_lock_nxt;
  logic [1:0] mask_r, mask_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic fault_r, fault_nxt;
  logic [NUM_CH-1:0] oc_trip;

  // per-channel overcurrent filters
  // filter instances
  for (genvar c = 0; c < NUM_CH; c++) begin : g_filt
    oc_filter_if fif ();
    assign fif.raw = oc_s2_r[c];
    assign fif.arm = on_r[c];
    assign oc_trip[c] = fif.trip;
    oc_filter u_filt (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .clk_en_i(clk_en_i),
      .fi(fif)
    );
  end

  // decode setpoint address to channel
  function automatic logic sp_hit(input logic [ADDR_W-1:0] a, input int c);
    return (c == 0) ? (a == ADDR_SP0) : (a == ADDR_SP1);
  endfunction

  logic diag_rd;
  assign diag_rd = rd_i && (addr_i == ADDR_DIAG);

  // fault, setpoint and enable next state
  always_comb begin
    mask_nxt = mask_r;
    ov_flag_nxt = ov_flag_r;
    uv_flag_nxt = uv_flag_r;
    uv_lock_nxt = uv_lock_r;
    if (wr_i && addr_i == ADDR_MASK) begin
      mask_nxt = wdata_i[MASK_CH_POS +: 2];
    end
    if (diag_rd && !ov_s2_r) begin
      ov_flag_nxt = 1'b0;
    end
    if (ov_s2_r) begin
      ov_flag_nxt = 1'b1;
    end
    if (diag_rd && !uv_s2_r) begin
      uv_flag_nxt = 1'b0;
      uv_lock_nxt = 1'b0;
    end
    if (uv_s2_r) begin
      uv_flag_nxt = 1'b1;
      uv_lock_nxt = 1'b1;
    end
    for (int c = 0; c < NUM_CH; c++) begin
      on_nxt[c] = on_r[c];
      sp_nxt[c] = sp_r[c];
      oc_flag_nxt[c] = oc_flag_r[c];
      ot_flag_nxt[c] = ot_flag_r[c];
      ot_lock_nxt[c] = ot_lock_r[c];
      if (wr_i && sp_hit(addr_i, c)) begin
        sp_nxt[c] = wdata_i[SP_W-1:0];
        on_nxt[c] = (wdata_i[SP_W-1:0] != SP_ZERO);
      end
      if (diag_rd) begin
        oc_flag_nxt[c] = 1'b0;
      end
      // overtemperature clear needs read and cool
      if (diag_rd && !ot_s2_r[c]) begin
        ot_flag_nxt[c] = 1'b0;
      end
      // lock until temperature drops by hysteresis
      if (!ot_s2_r[c]) begin
        ot_lock_nxt[c] = 1'b0;
      end
      if (oc_trip[c]) begin
        oc_flag_nxt[c] = 1'b1;
        on_nxt[c] = 1'b0;
        sp_nxt[c] = SP_ZERO;
      end
      if (ot_s2_r[c]) begin
        ot_flag_nxt[c] = 1'b1;
        ot_lock_nxt[c] = 1'b1;
        on_nxt[c] = 1'b0;
        sp_nxt[c] = SP_ZERO;
      end
      if (ov_s2_r || uv_s2_r || uv_lock_nxt || ot_lock_r[c]) begin
        on_nxt[c] = 1'b0;
        sp_nxt[c] = SP_ZERO;
      end
    end
    fault_nxt = ov_flag_nxt || uv_flag_nxt ||
                (((oc_flag_nxt | ot_flag_nxt) & mask_nxt) != 2'h0);
  end

  // read mux, registered one cycle after strobe
  always_comb begin
    rdata_nxt = '0;
    if (rd_i) begin
      case (addr_i)
        ADDR_DIAG: begin
          rdata_nxt[DIAG_OC_POS +: 2] = oc_flag_r;
          rdata_nxt[DIAG_OT_POS +: 2] = ot_flag_r;
          rdata_nxt[DIAG_OV_POS] = ov_flag_r;
          rdata_nxt[DIAG_CHARGE_PUMP_UNDERVOLTAGE_FLAG_POS] = uv_flag_r;
          rdata_nxt[DIAG_ON_POS +: 2] = on_r;
        end
        ADDR_SP0: rdata_nxt[SP_W-1:0] = sp_r[0];
        ADDR_SP1: rdata_nxt[SP_W-1:0] = sp_r[1];
        ADDR_MASK: rdata_nxt[MASK_CH_POS +: 2] = mask_r;
        default: rdata_nxt = '0;
      endcase
    end
  end

  // register all state
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      on_r <= '0;
      sp_r[0] <= SP_ZERO;
      sp_r[1] <= SP_ZERO;
      oc_flag_r <= '0;
      ot_flag_r <= '0;
      ot_lock_r <= '0;
      ov_flag_r <= 1'b0;
      uv_flag_r <= 1'b0;
      uv_lock_r <= 1'b0;
      mask_r <= MASK_RST;
      rdata_r <= '0;
      fault_r <= 1'b0;
    end else if (clk_en_i) begin
      on_r <= on_nxt;
      sp_r[0] <= sp_nxt[0];
      sp_r[1] <= sp_nxt[1];
      oc_flag_r <= oc_flag_nxt;
      ot_flag_r <= ot_flag_nxt;
      ot_lock_r <= ot_lock_nxt;
      ov_flag_r <= ov_flag_nxt;
      uv_flag_r <= uv_flag_nxt;
      uv_lock_r <= uv_lock_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
      fault_r <= fault_nxt;
    end
  end

  // outputs straight from flip-flops, except the fault pin level, which is tied low
  assign rdata_o = rdata_r;
  assign ch_on_o = on_r;
  assign sp0_o = sp_r[0];
  assign sp1_o = sp_r[1];
  assign fault_output_low_active_o = 1'b0; // pin only ever pulled low
  assign fault_oe_o = fault_r;
endmodule

// ### hw/fault_prot_pkg.sv
package fault_prot_pkg;
  // channel count and register bus shape
  localparam int NUM_CH = 2;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  // overcurrent filter window in system clock cycles
  localparam int OC_FILT_MIN_CYC = 20;
  localparam int OC_FILT_MAX_CYC = 40;
  // chosen filter length, inside the window
  localparam logic [5:0] OC_FILT_CYC = 6'h1E;
  // setpoint width and zero value
  localparam int SP_W = 12;
  localparam logic [11:0] SP_ZERO = 12'h000;
  // register offsets (byte addresses)
  localparam logic [3:0] ADDR_DIAG = 4'h0;
  localparam logic [3:0] ADDR_SP0 = 4'h4;
  localparam logic [3:0] ADDR_SP1 = 4'h8;
  localparam logic [3:0] ADDR_MASK = 4'hC;
  // diagnosis field positions
  localparam int DIAG_OC_POS = 0;
  localparam int DIAG_OT_POS = 2;
  localparam int DIAG_OV_POS = 4;
  localparam int DIAG_CHARGE_PUMP_UNDERVOLTAGE_FLAG_POS = 5;
  localparam int DIAG_ON_POS = 8;
  // mask field positions and reset value
  localparam int MASK_CH_POS = 0;
  localparam logic [1:0] MASK_RST = 2'h3;
  // filter state type
  typedef enum logic [1:0] {
    FILT_IDLE,
    FILT_COUNT,
    FILT_TRIP
  } filt_state_t;
endpackage

// ### hw/oc_filter_if.sv
`timescale 1ns/1ps
// carries one channel's comparator level and qualified trip pulse
interface oc_filter_if;
  logic raw;
  logic arm;
  logic trip;
  modport ctrl (output raw, output arm, input trip);
  modport filt (input raw, input arm, output trip);
endinterface

// ### hw/oc_filter.sv
`timescale 1ns/1ps
module oc_filter
  import fault_prot_pkg::*;
(
  input wire logic ref_clk_i, // system clock
  input wire logic sys_rst_i, // synchronous reset
  input wire logic clk_en_i, // freezes state when low
  oc_filter_if.filt fi // comparator in, trip out
);
  filt_state_t state_r, state_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic trip_r, trip_nxt;

  assign fi.trip = trip_r;

  // persistence counter, trips once after the filter length
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    trip_nxt = 1'b0;
    case (state_r)
      FILT_IDLE: begin
        cnt_nxt = 6'h00;
        if (fi.raw && fi.arm) begin
          state_nxt = FILT_COUNT;
          cnt_nxt = 6'h01;
        end
      end
      FILT_COUNT: begin
        if (!fi.raw || !fi.arm) begin
          state_nxt = FILT_IDLE;
        end else if (cnt_r == OC_FILT_CYC - 6'h01) begin
          state_nxt = FILT_TRIP;
          trip_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 6'h01;
        end
      end
      FILT_TRIP: begin
        if (!fi.raw || !fi.arm) begin
          state_nxt = FILT_IDLE;
        end
      end
      default: state_nxt = FILT_IDLE;
    endcase
  end

  // registers
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_r <= FILT_IDLE;
      cnt_r <= 6'h00;
      trip_r <= 1'b0;
    end else if (clk_en_i) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      trip_r <= trip_nxt;
    end
  end
endmodule

// ### bench/fault_prot_assertions.sv
`timescale 1ns/1ps
module fault_prot_assertions
  import fault_prot_pkg::*;
(
  input wire logic ref_clk_i, // clock
  input wire logic sys_rst_i, // reset
  input wire logic clk_en_i, // enable
  input wire logic [fault_prot_pkg::NUM_CH-1:0] oc_cmp_i, // oc
  input wire logic [fault_prot_pkg::NUM_CH-1:0] ot_hot_i, // ot
  input wire logic bat_ov_i, // ov
  input wire logic cp_uv_i, // charge_pump_undervoltage_flag
  input wire logic [fault_prot_pkg::ADDR_W-1:0] addr_i, // address
  input wire logic [fault_prot_pkg::DATA_W-1:0] wdata_i, // wdata
  input wire logic wr_i, // write
  input wire logic rd_i, // read
  input logic [fault_prot_pkg::DATA_W-1:0] rdata_o, // rdata
  input logic [fault_prot_pkg::NUM_CH-1:0] ch_on_o, // enables
  input logic [fault_prot_pkg::SP_W-1:0] sp0_o, // sp0
  input logic [fault_prot_pkg::SP_W-1:0] sp1_o, // sp1
  input logic fault_oe_o // pin drive
);
  logic [7:0] oc_run_r;
  logic [7:0] oc_run_nxt;
  // run length of channel 0 overcurrent, restarted by a write to ADDR_SP0
  always_comb begin
    oc_run_nxt = oc_run_r;
    if (wr_i && addr_i == ADDR_SP0) oc_run_nxt = 8'h00;
    else if (clk_en_i) oc_run_nxt = !oc_cmp_i[0] ? 8'h00 : oc_run_r + 8'(oc_run_r != 8'hFF);
  end
  always_ff @(posedge ref_clk_i) oc_run_r <= sys_rst_i ? 8'h00 : oc_run_nxt;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_ov_all_off: assert property (
    (bat_ov_i && clk_en_i) [*5] |-> ch_on_o == 2'h0 && sp0_o == SP_ZERO && sp1_o == SP_ZERO)
    else $error("channel active during overvoltage");
  a_charge_pump_undervoltage_flag_all_off: assert property (
    (cp_uv_i && clk_en_i) [*5] |-> ch_on_o == 2'h0 && sp0_o == SP_ZERO && sp1_o == SP_ZERO)
    else $error("channel active during pump undervoltage");
  a_ot_ch_off: assert property (
    (ot_hot_i[1] && clk_en_i) [*5] |-> !ch_on_o[1] && sp1_o == SP_ZERO)
    else $error("hot channel still on");
  a_oc_filter_max: assert property (oc_run_r >= 8'h2C |-> !ch_on_o[0])
    else $error("overcurrent not cut in time");
  a_ov_pin_low: assert property ((bat_ov_i && clk_en_i) [*5] |-> fault_oe_o)
    else $error("fault pin idle in overvoltage");
  a_ov_flag_read: assert property (
    (bat_ov_i && clk_en_i) [*5] ##0 (rd_i && addr_i == ADDR_DIAG) |=> rdata_o[DIAG_OV_POS])
    else $error("overvoltage flag lost");
  a_ot_flag_read: assert property (
    (ot_hot_i[1] && clk_en_i) [*5] ##0 (rd_i && addr_i == ADDR_DIAG) |=> rdata_o[DIAG_OT_POS+1])
    else $error("overtemperature flag lost");
  a_on_needs_wr: assert property (
    $rose(ch_on_o[0]) |-> $past(wr_i && addr_i == ADDR_SP0 && wdata_i[11:0] != SP_ZERO))
    else $error("channel on without setpoint write");
  c_ch_trip: cover property ($fell(ch_on_o[0]));
  c_ch_start: cover property ($rose(ch_on_o[1]));
  c_pin: cover property ($rose(fault_oe_o));
endmodule
bind channel_fault_protection fault_prot_assertions chk_u (.*);

// ### bench/host_model.sv
`timescale 1ns/1ps
module host_model
  import fault_prot_pkg::*;
(
  input wire logic ref_clk_i, // clock
  input wire logic [fault_prot_pkg::DATA_W-1:0] rdata_i, // read data
  output logic [fault_prot_pkg::ADDR_W-1:0] addr_o, // address
  output logic [fault_prot_pkg::DATA_W-1:0] wdata_o, // write data
  output logic wr_o, // write strobe
  output logic rd_o // read strobe
);
  // idle bus
  initial begin
    addr_o = 4'h0;
    wdata_o = 32'h0000_0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge ref_clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d; // no stale data once released
  endtask
  // one-cycle read, data taken at the edge that closes the answer cycle
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge ref_clk_i);
    rd_o <= 1'b0;
    @(posedge ref_clk_i);
    d = rdata_i;
  endtask
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import fault_prot_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] oc_cmp_i = 2'h0;
  logic [1:0] ot_hot_i = 2'h0;
  logic bat_ov_i = 1'b0;
  logic cp_uv_i = 1'b0;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, d;
  logic wr, rd, fpin, foe;
  logic [1:0] ch_on;
  logic [11:0] sp0, sp1, s0, s1;
  int n_errors = 0;
  int checks_done = 0;
  int n;
  int exp_sp [2] = '{0, 0};
  // clock
  always #2 ref_clk_i = ~ref_clk_i;
  host_model hm_u (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  channel_fault_protection dut_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(1'b1), .oc_cmp_i(oc_cmp_i), .ot_hot_i(ot_hot_i), .bat_ov_i(bat_ov_i),
    .cp_uv_i(cp_uv_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .ch_on_o(ch_on), .sp0_o(sp0), .sp1_o(sp1), .fault_output_low_active_o(fpin),
    .fault_oe_o(foe));
  // comparison and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge ref_clk_i);
  endtask
  // channel is on exactly when the model setpoint is nonzero
  task automatic chk_model;
    chk(32'(ch_on), 32'({exp_sp[1] != 0, exp_sp[0] != 0}));
    chk(32'(sp0), exp_sp[0]);
    chk(32'(sp1), exp_sp[1]);
  endtask
  task automatic set_sp(input logic [3:0] a, input logic [11:0] v);
    hm_u.wr_reg(a, {20'h0_0000, v});
    wt(2);
  endtask
  task automatic rdd;
    hm_u.rd_reg(ADDR_DIAG, d);
  endtask
  // main sequence
  initial begin
    void'($urandom(32'hb940));
    s0 = 12'($urandom_range(4095, 1));
    s1 = 12'($urandom_range(4095, 1));
    wt(2);
    sys_rst_i <= 1'b0;
    wt(1);
    chk_model;
    chk(32'(fpin), 32'h0);
    hm_u.rd_reg(4'h2, d);
    chk(d, 32'h0000_0000);
    set_sp(ADDR_SP0, s0);
    set_sp(ADDR_SP1, s1);
    exp_sp = '{s0, s1};
    chk_model;
    oc_cmp_i <= 2'h1;
    wt(15);
    oc_cmp_i <= 2'h0;
    wt(5);
    chk_model;
    oc_cmp_i <= 2'h1;
    n = 0;
    while (ch_on[0] === 1'b1 && n < 60) begin
      wt(1);
      n++;
    end
    chk(32'(n >= 20 && n <= 43), 32'h1);
    exp_sp[0] = 0;
    chk_model;
    chk(32'(foe), 32'h1);
    rdd;
    chk(32'(d[1:0]), 32'h1);
    rdd;
    chk(32'(d[1:0]), 32'h0);
    oc_cmp_i <= 2'h0;
    wt(3);
    chk(32'(foe), 32'h0);
    set_sp(ADDR_SP0, s0);
    exp_sp[0] = s0;
    chk_model;
    hm_u.wr_reg(ADDR_MASK, 32'h0000_0001);
    ot_hot_i <= 2'h2;
    wt(5);
    chk(32'(foe), 32'h0);
    exp_sp[1] = 0;
    chk_model;
    hm_u.rd_reg(ADDR_MASK, d);
    chk(d, 32'h0000_0001);
    hm_u.wr_reg(ADDR_MASK, 32'h0000_0003);
    wt(1);
    chk(32'(foe), 32'h1);
    set_sp(ADDR_SP1, s1);
    chk_model;
    rdd;
    rdd;
    chk(32'(d[3:2]), 32'h2);
    ot_hot_i <= 2'h0;
    wt(4);
    rdd;
    chk(32'(d[3:2]), 32'h2);
    rdd;
    chk(32'(d[3:2]), 32'h0);
    set_sp(ADDR_SP1, s1);
    exp_sp[1] = s1;
    chk_model;
    bat_ov_i <= 1'b1;
    wt(5);
    exp_sp = '{0, 0};
    chk_model;
    chk(32'(foe), 32'h1);
    rdd;
    bat_ov_i <= 1'b0;
    wt(4);
    rdd;
    chk(32'(d[4]), 32'h1);
    rdd;
    chk(32'(d[4]), 32'h0);
    set_sp(ADDR_SP0, s0);
    exp_sp[0] = s0;
    cp_uv_i <= 1'b1;
    wt(5);
    exp_sp[0] = 0;
    chk_model;
    cp_uv_i <= 1'b0;
    wt(4);
    set_sp(ADDR_SP0, s0);
    chk_model;
    rdd;
    chk(32'(d[5]), 32'h1);
    set_sp(ADDR_SP0, s0);
    exp_sp[0] = s0;
    chk_model;
    finish_test;
  end
endmodule
